// File: shared/tx_power_pkg.sv
// Behaviour
// - faults, disable or reset ramp the boost reference down at the fast rate
// - software lowering the boost target moves the reference at the slow rate
// - amplifier drives are disabled only after the ramp-down completes
// - hard reset: after ramp-down drop buck and regulator, then the oscillator
// - enables auto-clear on shutdown; rewrites before ramp end are applied then, except on a hard reset
// - discriminator steps an 8-bit reference code from current-sense comparisons
// - sense compared with upper and lower thresholds once per sample interval
// - window mode: below lower step up, above upper step down, else hold
// - continuous mode: always step each interval, up at or below the upper threshold, down above it
// - programmed reference acts as an upper clamp in discriminator modes
// - the discriminator-driven code is not visible to software
// - power-good always reads in range while the discriminator drives
// - comparator outputs may be routed to the two general-purpose pins
// - test mode: comparator results never move the reference code
// - amplifier gate outputs toggle at a quarter of the oscillator clock
// - each amplifier output has its own phase select and enable
// - amplifier outputs low when disabled, at reset, and without valid clock
// - amplifier master enable sits beside boost enable for a single write
// - with power-good gating, amplifier enable waits once for power-good
// - amplifier over-current flags an event and optionally shuts down
// - optional timeout while boost and amplifier enabled triggers a hard reset
// - current-limit sense sets after 64 consecutive limited cycles
package tx_power_pkg;
   // ----------------------------------------------------------------
   // sizes and timing
   // ----------------------------------------------------------------
   localparam int DAC_W          = 8;
   localparam int NUM_AMP        = 4;
   localparam int NUM_IMP        = 3;
   localparam int LIMIT_CYCLES   = 64;
   localparam int CLK_HZ         = 20_000_000;
   localparam int FAST_STEP_NS   = 100;
   localparam int FAST_STEP_CYC  = (FAST_STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int TIMEOUT_MS     = 1000;
   localparam int TIMEOUT_CYC    = TIMEOUT_MS * (CLK_HZ / 1000);
   localparam logic [DAC_W-1:0] DAC_RESET = 8'h00;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DISC_OFF,
      DISC_WINDOW,
      DISC_CONT,
      DISC_TEST
   } disc_mode_t;

   typedef enum logic [2:0] {
      SEQ_RUN,
      SEQ_RAMP_DOWN,
      SEQ_SUPPLY_OFF,
      SEQ_OSC_OFF
   } seq_state_t;

   typedef struct packed {
      logic boost_en;
      logic amp_master_en;
      logic [NUM_AMP-1:0] amp_en;
   } enables_t;

   typedef struct packed {
      logic boost_ov;
      logic boost_oc;
      logic amp_oc;
      logic amp_ot;
      logic peak;
   } faults_t;
endpackage : tx_power_pkg

// File: hdl/tx_power_drive_control.sv
`timescale 1ns/1ns
module tx_power_drive_control #(
   parameter int TIMEOUT_CYCLES = tx_power_pkg::TIMEOUT_CYC,
   parameter int FAST_CYCLES    = tx_power_pkg::FAST_STEP_CYC,
   parameter int SLOW_CYCLES    = 20
) (
   // clock and reset
   input  wire logic                           i_clk,
   input  wire logic                           i_reset,
   // configuration written by software
   input  wire tx_power_pkg::enables_t         i_enables,
   input  wire logic                           i_enables_wr,
   input  wire logic [7:0]                     i_dac_setting,
   input  wire tx_power_pkg::disc_mode_t       i_disc_mode,
   input  wire logic [7:0]                     i_thr_high,
   input  wire logic [7:0]                     i_thr_low,
   input  wire logic [7:0]                     i_step_size,
   input  wire logic [15:0]                    i_sample_cycles,
   input  wire logic                           i_route_gpio,
   input  wire logic [7:0]                     i_amp_phase,
   input  wire logic                           i_amp_enable_on_power_good,
   input  wire logic                           i_amp_oc_protect,
   input  wire logic                           i_timeout_en,
   input  wire logic                           i_reg_access,
   input  wire logic                           i_disable_req,
   input  wire logic                           i_hard_reset_req,
   input  wire logic                           i_sleep,
   input  wire logic                           i_impedance_master_enable,
   input  wire logic [2:0]                     i_impedance_driver_enable,
   // pins and analog status
   input  wire logic                           i_transmit_current_sense_input,
   input  wire logic [7:0]                     i_sense_level,
   input  wire logic                           i_osc_valid,
   input  wire logic                           i_boost_pg_raw,
   input  wire logic                           i_current_limited,
   input  wire tx_power_pkg::faults_t          i_faults,
   // outputs
   output logic [7:0]                          o_boost_ref,
   output logic                                o_boost_on,
   output logic                                o_power_good,
   output logic [3:0]                          o_amp_gate_output,
   output logic [2:0]                          o_impedance_drive_output,
   output logic [1:0]                          o_gpio,
   output logic                                o_current_limit_sense_bit,
   output logic                                o_amp_oc_event,
   output logic                                o_buck_ldo_on,
   output logic                                o_osc_on,
   output tx_power_pkg::enables_t              o_enables
);
   if (TIMEOUT_CYCLES < 2 || FAST_CYCLES < 1 || SLOW_CYCLES < 1 ||
       FAST_CYCLES > 65536 || SLOW_CYCLES > 65536) begin : g_bad_timing
      $error("bad timing parameters");
   end

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
      end else begin
         sync1_r <= {i_osc_valid, i_boost_pg_raw, i_current_limited,
                     i_transmit_current_sense_input};
         sync2_r <= sync1_r;
      end
   end
   logic osc_ok;
   logic pg_s;
   logic lim_s;
   assign osc_ok = sync2_r[3];
   assign pg_s   = sync2_r[2];
   assign lim_s  = sync2_r[1];

   // ----------------------------------------------------------------
   // current-limit debounce
   // ----------------------------------------------------------------
   logic [6:0] lim_cnt_r;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         lim_cnt_r                 <= 7'h00;
         o_current_limit_sense_bit <= 1'b0;
      end else begin
         if (!lim_s) begin
            lim_cnt_r <= 7'h00;
         end else if (lim_cnt_r != 7'(tx_power_pkg::LIMIT_CYCLES)) begin
            lim_cnt_r <= lim_cnt_r + 7'h01;
         end
         o_current_limit_sense_bit <= lim_s &&
            (lim_cnt_r >= 7'(tx_power_pkg::LIMIT_CYCLES - 1));
      end
   end

   // ----------------------------------------------------------------
   // shutdown sequencing
   // ----------------------------------------------------------------
   tx_power_pkg::seq_state_t state_r;
   tx_power_pkg::enables_t   pend_r;
   // enables in force at the drivers: held through a ramp-down so the amp stops last
   tx_power_pkg::enables_t   drive_r;
   logic                     hard_r;
   logic                     pend_wr_r;
   logic [31:0]              tmo_r;
   logic                     timeout_hit;
   logic                     amp_oc_s;
   logic                     fault_any;
   logic                     ramp_done;
   assign amp_oc_s    = i_faults.amp_oc;
   assign timeout_hit = i_timeout_en && (tmo_r == 32'(TIMEOUT_CYCLES - 1));
   assign fault_any   = i_faults.boost_ov || i_faults.boost_oc || i_faults.amp_ot ||
                        i_faults.peak || (amp_oc_s && i_amp_oc_protect) ||
                        i_disable_req || i_hard_reset_req || timeout_hit;
   assign ramp_done   = (o_boost_ref == 8'h00);

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state_r       <= tx_power_pkg::SEQ_RUN;
         o_enables     <= '0;
         pend_r        <= '0;
         drive_r       <= '0;
         pend_wr_r     <= 1'b0;
         hard_r        <= 1'b0;
         o_buck_ldo_on <= 1'b1;
         o_osc_on      <= 1'b1;
      end else begin
         unique case (state_r)
            tx_power_pkg::SEQ_RUN: begin
               if (fault_any) begin
                  state_r   <= tx_power_pkg::SEQ_RAMP_DOWN;
                  o_enables <= '0;
                  pend_r    <= '0;
                  pend_wr_r <= 1'b0;
                  hard_r    <= i_hard_reset_req || timeout_hit;
               end else if (i_enables_wr) begin
                  o_enables <= i_enables;
                  drive_r   <= i_enables;
               end
            end
            tx_power_pkg::SEQ_RAMP_DOWN: begin
               if (i_enables_wr) begin
                  pend_r    <= i_enables;
                  pend_wr_r <= 1'b1;
               end
               if (ramp_done) begin
                  if (hard_r) begin
                     state_r <= tx_power_pkg::SEQ_SUPPLY_OFF;
                     drive_r <= '0;
                  end else begin
                     state_r   <= tx_power_pkg::SEQ_RUN;
                     o_enables <= pend_wr_r ? pend_r : '0;
                     drive_r   <= pend_wr_r ? pend_r : '0;
                  end
               end
            end
            tx_power_pkg::SEQ_SUPPLY_OFF: begin
               o_buck_ldo_on <= 1'b0;
               state_r       <= tx_power_pkg::SEQ_OSC_OFF;
            end
            tx_power_pkg::SEQ_OSC_OFF: begin
               o_osc_on <= 1'b0;
            end
            default: state_r <= tx_power_pkg::SEQ_RAMP_DOWN;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // access timeout
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         tmo_r <= 32'h0;
      end else if (!i_timeout_en || i_reg_access || !o_enables.boost_en ||
                   !o_enables.amp_master_en || state_r != tx_power_pkg::SEQ_RUN) begin
         tmo_r <= 32'h0;
      end else if (!timeout_hit) begin
         tmo_r <= tmo_r + 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // discriminator
   // ----------------------------------------------------------------
   // the stepped reference code is held in this register and leaves the block only through the ramp target
   logic [7:0]  disc_code_r;
   logic [15:0] samp_cnt_r;
   logic        below_r;
   logic        above_r;
   logic        disc_on;
   logic        sample;
   assign disc_on = (i_disc_mode != tx_power_pkg::DISC_OFF);
   assign sample  = (samp_cnt_r == 16'h0000);

   function automatic logic [7:0] sat_step(input logic [7:0] v, input logic [7:0] s,
                                           input logic up, input logic [7:0] lim);
      logic [8:0] t;
      t = 9'h000;
      if (up) begin
         t = {1'b0, v} + {1'b0, s};
         sat_step = (t > {1'b0, lim}) ? lim : t[7:0];
      end else begin
         sat_step = (v > s) ? v - s : 8'h00;
      end
   endfunction : sat_step

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         samp_cnt_r  <= 16'h0000;
         below_r     <= 1'b0;
         above_r     <= 1'b0;
         disc_code_r <= tx_power_pkg::DAC_RESET;
      end else begin
         samp_cnt_r <= sample ? i_sample_cycles : samp_cnt_r - 16'h0001;
         if (sample) begin
            below_r <= i_sense_level < i_thr_low;
            above_r <= i_sense_level > i_thr_high;
            unique case (i_disc_mode)
               tx_power_pkg::DISC_WINDOW: begin
                  if (i_sense_level < i_thr_low) begin
                     disc_code_r <= sat_step(disc_code_r, i_step_size, 1'b1, i_dac_setting);
                  end else if (i_sense_level > i_thr_high) begin
                     disc_code_r <= sat_step(disc_code_r, i_step_size, 1'b0, i_dac_setting);
                  end
               end
               tx_power_pkg::DISC_CONT: begin
                  disc_code_r <= sat_step(disc_code_r, i_step_size,
                                          i_sense_level <= i_thr_high, i_dac_setting);
               end
               tx_power_pkg::DISC_TEST: begin
                  disc_code_r <= disc_code_r;
               end
               tx_power_pkg::DISC_OFF: begin
                  disc_code_r <= tx_power_pkg::DAC_RESET;
               end
            endcase
         end
         if (disc_on && disc_code_r > i_dac_setting) begin
            disc_code_r <= i_dac_setting;
         end
      end
   end
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_gpio <= 2'b00;
      end else begin
         o_gpio <= (disc_on && i_route_gpio) ? {above_r, below_r} : 2'b00;
      end
   end

   // ----------------------------------------------------------------
   // reference ramp
   // ----------------------------------------------------------------
   logic [7:0]  target;
   logic [15:0] ramp_cnt_r;
   logic        shutting;
   assign shutting = (state_r != tx_power_pkg::SEQ_RUN) || fault_any;
   always_comb begin
      target = 8'h00;
      if (!shutting && o_enables.boost_en && osc_ok && !i_sleep) begin
         target = (disc_on && i_disc_mode != tx_power_pkg::DISC_TEST) ?
                  disc_code_r : i_dac_setting;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_boost_ref <= 8'h00;
         ramp_cnt_r  <= 16'h0000;
         o_boost_on  <= 1'b0;
      end else begin
         o_boost_on <= (o_boost_ref != 8'h00) || (target != 8'h00);
         if (ramp_cnt_r != 16'h0000) begin
            ramp_cnt_r <= ramp_cnt_r - 16'h0001;
         end else if (o_boost_ref != target) begin
            o_boost_ref <= (o_boost_ref < target) ? o_boost_ref + 8'h01 : o_boost_ref - 8'h01;
            ramp_cnt_r  <= shutting ? 16'(FAST_CYCLES - 1)
                                    : 16'(SLOW_CYCLES - 1);
         end
      end
   end

   // ----------------------------------------------------------------
   // power good and amplifier enable
   // ----------------------------------------------------------------
   logic amp_arm_r;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_power_good   <= 1'b0;
         amp_arm_r      <= 1'b0;
         o_amp_oc_event <= 1'b0;
      end else begin
         o_power_good <= o_enables.boost_en &&
                         ((disc_on && state_r == tx_power_pkg::SEQ_RUN) || pg_s);
         o_amp_oc_event <= amp_oc_s;
         if (!drive_r.amp_master_en) begin
            amp_arm_r <= 1'b0;
         end else if (!i_amp_enable_on_power_good || o_power_good) begin
            amp_arm_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // gate drive: quarter-rate phase counter
   // ----------------------------------------------------------------
   // the system clock stands in for the oscillator; each output taps a 2-bit phase
   logic [1:0] ph_r;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         ph_r              <= 2'b00;
         o_amp_gate_output <= 4'h0;
      end else begin
         ph_r <= ph_r + 2'b01;
         for (int k = 0; k < tx_power_pkg::NUM_AMP; k++) begin
            o_amp_gate_output[k] <= amp_arm_r && drive_r.amp_en[k] && osc_ok && !i_sleep &&
                                    ((ph_r + i_amp_phase[2*k +: 2]) < 2'b10);
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_impedance_drive_output <= 3'b000;
      end else begin
         o_impedance_drive_output <= (i_impedance_master_enable && !i_sleep) ?
                                     i_impedance_driver_enable : 3'b000;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_fault_clears: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_r == tx_power_pkg::SEQ_RUN && fault_any) |=> (o_enables == '0))
      else $error("enables not cleared on shutdown");
   chk_amp_after_ramp: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_r == tx_power_pkg::SEQ_RAMP_DOWN && !ramp_done) |=> $stable(drive_r))
      else $error("amp drive changed before ramp end");
   chk_osc_after_sup: assert property (@(posedge i_clk) disable iff (i_reset)
      $fell(o_osc_on) |-> !o_buck_ldo_on && !$past(o_buck_ldo_on))
      else $error("oscillator off before supplies");
   chk_clamp_code: assert property (@(posedge i_clk) disable iff (i_reset)
      disc_on |=> (disc_code_r <= $past(i_dac_setting)))
      else $error("code above clamp");
   chk_test_hold: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_disc_mode == tx_power_pkg::DISC_TEST && $stable(i_disc_mode) &&
       disc_code_r <= i_dac_setting) |=> $stable(disc_code_r))
      else $error("test mode moved code");
   chk_amp_no_osc: assert property (@(posedge i_clk) disable iff (i_reset)
      !osc_ok |=> (o_amp_gate_output == 4'h0))
      else $error("amp driven without clock");
   chk_limit_debounce: assert property (@(posedge i_clk) disable iff (i_reset)
      $rose(o_current_limit_sense_bit) |-> $past(lim_cnt_r) == 7'h3F)
      else $error("limit sense early");
   chk_ref_step: assert property (@(posedge i_clk) disable iff (i_reset)
      (o_boost_ref != $past(o_boost_ref)) |=> $stable(o_boost_ref) || (FAST_CYCLES == 1))
      else $error("reference stepped too fast");
   chk_pg_disc: assert property (@(posedge i_clk) disable iff (i_reset)
      (disc_on && o_enables.boost_en && state_r == tx_power_pkg::SEQ_RUN) |=> o_power_good
       || !o_enables.boost_en || state_r != tx_power_pkg::SEQ_RUN)
      else $error("power good low in discriminator mode");
endmodule : tx_power_drive_control

// File: tb/tx_power_stage_model.sv
`timescale 1ns/1ns
module tx_power_stage_model (
   // clock and design side
   input  wire logic       i_clk,
   input  wire logic       i_osc_ok,
   input  wire logic       i_boost_on,
   input  wire logic [7:0] i_boost_ref,
   input  wire logic       i_limit,
   // status back to the design
   output logic            o_osc_valid,
   output logic            o_pg_raw,
   output logic            o_limited
);
   logic [7:0] last_r;
   // power-good only once the reference holds still: a real output settles late
   always_ff @(posedge i_clk) begin
      last_r   <= i_boost_ref;
      o_pg_raw <= i_boost_on && (last_r == i_boost_ref);
   end
   assign o_osc_valid = i_osc_ok;
   assign o_limited   = i_limit;
endmodule : tx_power_stage_model

// File: tb/test_tx_power_drive_control.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_tx_power_drive_control;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   localparam int SLOW = 4;
   localparam int FAST = 2;
   logic clk = 1'b0, rst = 1'b1, en_wr = 1'b0, acc = 1'b0, dis = 1'b0, hrst = 1'b0;
   logic osc_ok = 1'b1, lim = 1'b0, pgate = 1'b0, to_en = 1'b0, ocp = 1'b1, imp_m = 1'b0;
   logic slp = 1'b0, route = 1'b1;
   logic [2:0] imp = 3'h0;
   logic [7:0] dac = 8'h00, lvl = 8'h00, step = 8'h04, ref_q;
   logic [15:0] smp = 16'h0027;
   tx_power_pkg::enables_t en = '0, en_q;
   tx_power_pkg::disc_mode_t mode = tx_power_pkg::DISC_OFF;
   tx_power_pkg::faults_t flt = '0;
   logic bon, pg, lims, ocev, buck, osc, oscv, pgr, limd;
   logic [3:0] gate;
   logic [2:0] impo;
   logic [1:0] gpio;
   int n_mismatch = 0, n_tests = 0, cyc = 0, c;
   tx_power_drive_control #(.TIMEOUT_CYCLES(50), .FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW)) i_dut (
      .i_clk(clk), .i_reset(rst), .i_enables(en), .i_enables_wr(en_wr),
      .i_dac_setting(dac), .i_disc_mode(mode), .i_thr_high(8'h80), .i_thr_low(8'h40),
      .i_step_size(step), .i_sample_cycles(smp), .i_route_gpio(route),
      .i_amp_phase(8'h1B), .i_amp_enable_on_power_good(pgate), .i_amp_oc_protect(ocp),
      .i_timeout_en(to_en), .i_reg_access(acc), .i_disable_req(dis),
      .i_hard_reset_req(hrst), .i_sleep(slp), .i_impedance_master_enable(imp_m),
      .i_impedance_driver_enable(imp), .i_transmit_current_sense_input(1'b0),
      .i_sense_level(lvl), .i_osc_valid(oscv), .i_boost_pg_raw(pgr),
      .i_current_limited(limd), .i_faults(flt), .o_boost_ref(ref_q), .o_boost_on(bon),
      .o_power_good(pg), .o_amp_gate_output(gate), .o_impedance_drive_output(impo),
      .o_gpio(gpio), .o_current_limit_sense_bit(lims), .o_amp_oc_event(ocev),
      .o_buck_ldo_on(buck), .o_osc_on(osc), .o_enables(en_q));
   tx_power_stage_model i_stage (.i_clk(clk), .i_osc_ok(osc_ok), .i_boost_on(bon),
      .i_boost_ref(ref_q), .i_limit(lim), .o_osc_valid(oscv), .o_pg_raw(pgr),
      .o_limited(limd));
   always #25 clk = ~clk;
   // a hang ends the run through the same report
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic wr_en(input tx_power_pkg::enables_t v);
      en = v;
      en_wr = 1'b1;
      tick(1);
      en_wr = 1'b0;
   endtask : wr_en
   task automatic wait_ref(input logic [7:0] v);
      c = 0;
      while (ref_q !== v && c < 2000) begin
         tick(1);
         c++;
      end
      `CHK(ref_q, v)
   endtask : wait_ref
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      `CHK({ref_q, bon, gate, en_q, buck, osc}, {8'h00, 1'b0, 4'h0, 6'h00, 2'b11})
      imp_m = 1'b1;
      imp = 3'h5;
      tick(3);
      `CHK(impo, 3'h5)
      imp_m = 1'b0;
      tick(3);
      `CHK(impo, 3'h0)
      lim = 1'b1;
      tick(40);
      `CHK(lims, 1'b0)
      tick(40);
      `CHK(lims, 1'b1)
      lim = 1'b0;
   endtask : t_reset
   task automatic t_gate;
      logic [3:0] g [8];
      pgate = 1'b1;
      dac = 8'h05;
      wr_en('{1'b1, 1'b1, 4'hF});
      tick(8);
      `CHK(en_q, 6'h3F)
      for (int i = 0; i < 8; i++) begin
         g[i] = gate;
         `CHK(gate[1], ~gate[3])
         tick(1);
      end
      for (int i = 0; i < 4; i++) `CHK(g[i], g[i + 4])
      `CHK(g[0][0] + g[1][0] + g[2][0] + g[3][0], 2)
      wr_en('{1'b1, 1'b1, 4'hD});
      tick(2);
      for (int i = 0; i < 4; i++) begin
         `CHK(gate[1], 1'b0)
         tick(1);
      end
      slp = 1'b1;
      tick(1);
      `CHK(gate, 4'h0)
      slp = 1'b0;
      osc_ok = 1'b0;
      tick(5);
      `CHK(gate, 4'h0)
      osc_ok = 1'b1;
      wr_en('{1'b1, 1'b1, 4'hF});
   endtask : t_gate
   task automatic t_ramp;
      wait_ref(8'h05);
      dac = 8'h03;
      wait_ref(8'h03);
      `CHK(c >= 2 * SLOW - 1, 1'b1)
      flt.amp_oc = 1'b1;
      tick(2);
      `CHK(ocev, 1'b1)
      `CHK(gate != 4'h0, 1'b1)
      `CHK(en_q, 6'h00)
      flt = '0;
      wr_en('{1'b1, 1'b1, 4'hF});
      `CHK(en_q, 6'h00)
      wait_ref(8'h00);
      `CHK(c <= 3 * FAST + 3, 1'b1)
      tick(3);
      `CHK(en_q, 6'h3F)
   endtask : t_ramp
   task automatic t_disc;
      // interval 40 cycles outlasts step 6 times slow step 4
      step = 8'h06;
      dac = 8'h10;
      lvl = 8'h20;
      pgate = 1'b0;
      mode = tx_power_pkg::DISC_WINDOW;
      wait_ref(8'h10);
      tick(100);
      `CHK(ref_q, 8'h10)
      `CHK(pg, 1'b1)
      `CHK(gpio, 2'b01)
      route = 1'b0;
      tick(2);
      `CHK(gpio, 2'b00)
      route = 1'b1;
      lvl = 8'h60;
      tick(100);
      `CHK(ref_q, 8'h10)
      mode = tx_power_pkg::DISC_TEST;
      lvl = 8'h90;
      tick(100);
      `CHK(ref_q, 8'h10)
      `CHK(gpio, 2'b10)
      mode = tx_power_pkg::DISC_WINDOW;
      wait_ref(8'h00);
      mode = tx_power_pkg::DISC_CONT;
      lvl = 8'h60;
      wait_ref(8'h06);
      lvl = 8'h90;
      wait_ref(8'h00);
      mode = tx_power_pkg::DISC_OFF;
   endtask : t_disc
   task automatic t_timeout;
      dac = 8'h03;
      to_en = 1'b1;
      repeat (4) begin
         tick(30);
         acc = 1'b1;
         tick(1);
         acc = 1'b0;
      end
      `CHK(buck, 1'b1)
      c = 0;
      while (buck !== 1'b0 && c < 500) begin
         tick(1);
         c++;
      end
      `CHK({buck, ref_q, osc}, {1'b0, 8'h00, 1'b1})
      tick(50);
      `CHK(osc, 1'b0)
      `CHK(gate, 4'h0)
   endtask : t_timeout
   initial begin
      tick(10);
      rst = 1'b0;
      tick(2);
      t_reset();
      t_gate();
      t_ramp();
      t_disc();
      t_timeout();
      final_report();
   end
endmodule : test_tx_power_drive_control
